// >>> design/flash_access_ctrl.sv
`timescale 1ns/1ps
// Function
// - Erased code flash reads all ones; erased data flash undefined.
// - Each flash area stays readable while the other is busy.
// - Code flash programs in 128-byte units, erases in whole blocks.
// - Program/erase is commanded by writes to the command area.
// - Interrupts keep being serviced during self-programming.
// - Blank 128-bit ID code means no protection, connections admitted.
// - Programmed ID: always refuse, or admit on matching ID.
// - Region access: read-write and no write both refuse bus writes; no access refuses all.
// - A readable 16-byte unique identifier per chip.
// - Protected blocks refuse erase and program from any software.
// - Serial boot rate adapts automatically to the programmer.
// - Code flash offers block swap; data flash has none.
module flash_access_ctrl
   import flash_access_pkg::*;
#(
   // Arbitrary per-chip value
   parameter logic [127:0] UNIQUE_ID =
      128'h0123_4567_89AB_CDEF_0011_2233_4455_6677,
   parameter int ERASE_CYCLES_P = ERASE_CYCLES
)
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // CPU bus
   input wire logic bus_req_i,
   input wire logic bus_we_i,
   input wire logic [31:0] bus_addr_i,
   input wire logic [31:0] bus_wdata_i,
   input wire logic bus_secure_i,
   output logic bus_ack_o,
   output logic bus_err_o,
   output logic [31:0] bus_rdata_o,
   // Flash array port
   output logic fl_we_o,
   output logic fl_erase_o,
   output logic [1:0] fl_tgt_o,
   output logic [31:0] fl_addr_o,
   output logic [31:0] fl_wdata_o,
   input wire logic [31:0] code_rdata_i,
   input wire logic [31:0] data_rdata_i,
   // Option-setting memory contents
   input wire logic [127:0] id_code_i,
   input wire logic [1:0] debug_serial_id_setting_i,
   input wire logic [N_PROT_BLOCKS-1:0] block_prot_i,
   input wire logic [1:0] mpu_code_i,
   input wire logic [1:0] mpu_data_i,
   input wire logic swap_sel_i,
   // Debugger / boot programmer connection
   input wire logic conn_req_i,
   input wire logic [127:0] conn_id_i,
   input wire logic boot_rxd_i,
   output logic conn_grant_o,
   output logic conn_deny_o,
   output logic [15:0] boot_bit_cycles_o,
   output logic boot_locked_o,
   // Status
   output logic background_flash_operation_o,
   output logic irq_allowed_o
);

   seq_state_t st_q;
   logic [1:0] tgt_q;
   logic [31:0] op_addr_q;
   logic [31:0] cnt_q;
   logic [5:0] words_q;
   logic rx_meta_q, rx_sync_q, creq_meta_q, creq_sync_q;
   logic [15:0] bit_cycles;
   logic locked;

   logic hit_cmd, hit_code, hit_data, hit_uid;
   logic busy_code, busy_data;
   logic [4:0] blk_idx;
   logic [31:0] code_phys;

   assign hit_cmd = (bus_addr_i & CMD_AREA_MASK) == CMD_AREA_BASE;
   assign hit_code = (bus_addr_i & CODE_MASK) == CODE_BASE;
   assign hit_data = (bus_addr_i & DATA_MASK) == DATA_BASE;
   assign hit_uid = (bus_addr_i & UID_MASK) == UID_BASE;
   assign busy_code = (st_q != SEQ_IDLE) && (st_q != SEQ_ARMED)
                      && (tgt_q != TGT_DATA);
   assign busy_data = (st_q != SEQ_IDLE) && (st_q != SEQ_ARMED)
                      && (tgt_q == TGT_DATA);
   assign blk_idx = code_phys[BLOCK_IDX_LSB +: 5];
   // Swap steers updates into the partner block, live image untouched
   assign code_phys = bus_wdata_i
      ^ {18'h0, swap_sel_i && tgt_q == TGT_CODE, 13'h0};

   // ----------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
         creq_meta_q <= 1'b0;
         creq_sync_q <= 1'b0;
      end else begin
         rx_meta_q <= boot_rxd_i;
         rx_sync_q <= rx_meta_q;
         creq_meta_q <= conn_req_i;
         creq_sync_q <= creq_meta_q;
      end
   end

   baud_detect u_baud (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .rxd_i(rx_sync_q),
      .bit_cycles_o(bit_cycles),
      .locked_o(locked)
   );

   // ----------------------------------------------------------------
   // Command sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q <= SEQ_IDLE;
         tgt_q <= TGT_CODE;
         op_addr_q <= 32'h0000_0000;
         cnt_q <= 32'h0000_0000;
         words_q <= 6'h00;
         fl_we_o <= 1'b0;
         fl_erase_o <= 1'b0;
         fl_tgt_o <= TGT_CODE;
         fl_addr_o <= 32'h0000_0000;
         fl_wdata_o <= 32'h0000_0000;
      end else begin
         fl_we_o <= 1'b0;
         fl_erase_o <= 1'b0;
         case (st_q)
            SEQ_IDLE: begin
               // Command word: [7:0] code, [9:8] target
               if (bus_req_i && bus_we_i && hit_cmd) begin
                  if (bus_wdata_i[7:0] == CMD_PROGRAM
                      || bus_wdata_i[7:0] == CMD_ERASE) begin
                     tgt_q <= bus_wdata_i[9:8];
                     words_q <= 6'h00;
                     cnt_q <= {24'h0, bus_wdata_i[7:0]};
                     st_q <= SEQ_ARMED;
                  end
               end
            end
            SEQ_ARMED: begin
               if (bus_req_i && bus_we_i && hit_cmd) begin
                  if (cnt_q[7:0] == CMD_ERASE) begin
                     // Erase starts on the block address word
                     op_addr_q <= {code_phys[31:BLOCK_IDX_LSB],
                                   13'h0};
                     cnt_q <= 32'(ERASE_CYCLES_P);
                     if (tgt_q == TGT_CODE && block_prot_i[blk_idx])
                        st_q <= SEQ_IDLE;
                     else
                        st_q <= SEQ_ERASE;
                  end else if (words_q == 6'(CODE_PROG_WORDS + 1)) begin
                     st_q <= (bus_wdata_i[7:0] == CMD_CONFIRM)
                             ? SEQ_PROG : SEQ_IDLE;
                     cnt_q <= 32'(PROG_WORD_CYCLES);
                  end else begin
                     // First word is the unit address, then 32 data words
                     if (words_q == 6'h00) begin
                        op_addr_q <= {code_phys[31:7], 7'h00};
                        if (tgt_q == TGT_CODE
                            && block_prot_i[blk_idx])
                           st_q <= SEQ_IDLE;
                     end
                     fl_we_o <= words_q != 6'h00;
                     fl_tgt_o <= tgt_q;
                     fl_addr_o <= op_addr_q
                                  + {24'h0, words_q - 6'h01, 2'b00};
                     fl_wdata_o <= bus_wdata_i;
                     words_q <= words_q + 6'h01;
                  end
               end
            end
            SEQ_PROG, SEQ_ERASE: begin
               if (cnt_q == 32'h0000_0001) begin
                  st_q <= SEQ_IDLE;
                  fl_erase_o <= (st_q == SEQ_ERASE);
                  fl_tgt_o <= tgt_q;
                  fl_addr_o <= op_addr_q;
               end else begin
                  cnt_q <= cnt_q - 32'h0000_0001;
               end
            end
            default: st_q <= SEQ_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Bus read path and protection
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bus_ack_o <= 1'b0;
         bus_err_o <= 1'b0;
         bus_rdata_o <= 32'h0000_0000;
      end else begin
         bus_ack_o <= 1'b0;
         bus_err_o <= 1'b0;
         bus_rdata_o <= 32'h0000_0000;
         if (bus_req_i) begin
            if (hit_cmd) begin
               bus_ack_o <= bus_we_i;
               bus_err_o <= !bus_we_i;
            end else if (hit_uid && !bus_we_i) begin
               bus_ack_o <= 1'b1;
               bus_rdata_o <= UNIQUE_ID[{bus_addr_i[3:2], 5'h00} +: 32];
            end else if (hit_code) begin
               if (busy_code || bus_we_i
                   || mpu_code_i == MPU_NO_ACCESS) begin
                  bus_err_o <= 1'b1;
               end else begin
                  bus_ack_o <= 1'b1;
                  // Erased cells come back as all ones from the array
                  bus_rdata_o <= code_rdata_i;
               end
            end else if (hit_data) begin
               if (busy_data || mpu_data_i == MPU_NO_ACCESS
                   || (bus_we_i && mpu_data_i == MPU_NO_WRITE)
                   || bus_we_i) begin
                  bus_err_o <= 1'b1;
               end else begin
                  bus_ack_o <= 1'b1;
                  bus_rdata_o <= data_rdata_i;
               end
            end else begin
               bus_err_o <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Debugger / serial boot gating
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         conn_grant_o <= 1'b0;
         conn_deny_o <= 1'b0;
      end else if (creq_sync_q && !conn_grant_o && !conn_deny_o) begin
         if (id_code_i == ID_BLANK)
            conn_grant_o <= 1'b1;
         else if (debug_serial_id_setting_i == ID_MODE_MATCH
                  && conn_id_i == id_code_i)
            conn_grant_o <= 1'b1;
         else
            conn_deny_o <= 1'b1;
      end else if (!creq_sync_q) begin
         conn_grant_o <= 1'b0;
         conn_deny_o <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Status outputs
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         background_flash_operation_o <= 1'b0;
         irq_allowed_o <= 1'b1;
         boot_bit_cycles_o <= 16'h0000;
         boot_locked_o <= 1'b0;
      end else begin
         background_flash_operation_o <= busy_code || busy_data;
         // No masking is imposed while flash is busy
         irq_allowed_o <= 1'b1;
         boot_bit_cycles_o <= bit_cycles;
         boot_locked_o <= locked;
      end
   end

endmodule

// >>> design/flash_access_pkg.sv
package flash_access_pkg;

   // ----------------------------------------------------------------
   // Address map
   // ----------------------------------------------------------------
   localparam logic [31:0] CMD_AREA_BASE = 32'h407E_0000;
   localparam logic [31:0] CMD_AREA_MASK = 32'hFFFF_0000;
   localparam logic [31:0] CODE_BASE = 32'h0000_0000;
   localparam logic [31:0] CODE_MASK = 32'hFFF0_0000;
   localparam logic [31:0] DATA_BASE = 32'h0800_0000;
   localparam logic [31:0] DATA_MASK = 32'hFFFF_E000;
   localparam logic [31:0] UID_BASE = 32'h0100_8190;
   localparam logic [31:0] UID_MASK = 32'hFFFF_FFF0;

   // ----------------------------------------------------------------
   // Flash geometry and erased values
   // ----------------------------------------------------------------
   localparam int CODE_PROG_BYTES = 128;
   localparam int CODE_PROG_WORDS = CODE_PROG_BYTES / 4;
   localparam int CODE_BLOCK_BYTES = 8192;
   localparam int BLOCK_IDX_LSB = 13;
   localparam int N_PROT_BLOCKS = 32;
   localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
   localparam logic [127:0] ID_BLANK = {16{8'hFF}};

   // ----------------------------------------------------------------
   // Command words written to the command area
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_PROGRAM = 8'hE8;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_CONFIRM = 8'hD0;
   localparam logic [1:0] TGT_CODE = 2'h0;
   localparam logic [1:0] TGT_DATA = 2'h1;
   localparam logic [1:0] TGT_OPT = 2'h2;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int ERASE_TIME_US = 20;
   localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
   localparam int PROG_WORD_CYCLES = 4;
   localparam int BAUD_MIN_CYCLES = 4;

   // ----------------------------------------------------------------
   // Region access settings
   // ----------------------------------------------------------------
   localparam logic [1:0] MPU_RW = 2'h0;
   localparam logic [1:0] MPU_NO_WRITE = 2'h1;
   localparam logic [1:0] MPU_NO_ACCESS = 2'h3;

   localparam logic [1:0] ID_MODE_REFUSE = 2'h0;
   localparam logic [1:0] ID_MODE_MATCH = 2'h1;

   typedef enum logic [3:0] {
      SEQ_IDLE = 4'h1,
      SEQ_ARMED = 4'h2,
      SEQ_PROG = 4'h4,
      SEQ_ERASE = 4'h8
   } seq_state_t;

endpackage

// >>> design/baud_detect.sv
`timescale 1ns/1ps
module baud_detect
   import flash_access_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // Synchronised serial line
   input wire logic rxd_i,
   // Measured bit period
   output logic [15:0] bit_cycles_o,
   output logic locked_o
);

   logic rxd_q;
   logic [15:0] cnt_q;
   logic meas_q;

   // ----------------------------------------------------------------
   // Width of first low pulse (start bit of 0x00 sync) sets the rate
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rxd_q <= 1'b1;
         cnt_q <= 16'h0000;
         meas_q <= 1'b0;
         bit_cycles_o <= 16'h0000;
         locked_o <= 1'b0;
      end else begin
         rxd_q <= rxd_i;
         if (!locked_o) begin
            if (rxd_q && !rxd_i) begin
               meas_q <= 1'b1;
               cnt_q <= 16'h0001;
            end else if (meas_q && !rxd_i && cnt_q != 16'hFFFF) begin
               cnt_q <= cnt_q + 16'h0001;
            end else if (meas_q && rxd_i) begin
               meas_q <= 1'b0;
               // Glitches shorter than a few cycles are not a rate
               if (cnt_q >= 16'(BAUD_MIN_CYCLES)) begin
                  bit_cycles_o <= cnt_q;
                  locked_o <= 1'b1;
               end
            end
         end
      end
   end

endmodule

// >>> testbench/flash_access_props.sv
`timescale 1ns/1ps
module flash_access_props
   import flash_access_pkg::*;
#(
   parameter logic [127:0] UNIQUE_ID = 128'h0
)
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   // Bus
   input wire logic bus_req_i,
   input wire logic bus_we_i,
   input wire logic [31:0] bus_addr_i,
   input wire logic bus_ack_o,
   input wire logic bus_err_o,
   input wire logic [31:0] bus_rdata_o,
   input wire logic [31:0] code_rdata_i,
   input wire logic [1:0] mpu_code_i,
   input wire logic background_flash_operation_o,
   input wire logic irq_allowed_o,
   // Connection
   input wire logic [127:0] id_code_i,
   input wire logic [1:0] debug_serial_id_setting_i,
   input wire logic conn_req_i,
   input wire logic conn_grant_o,
   input wire logic conn_deny_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_rd;
      bus_req_i && !bus_we_i;
   endsequence
   sequence s_code_rd;
      s_rd ##0 ((bus_addr_i & CODE_MASK) == CODE_BASE);
   endsequence
   property p_code_ok;
      s_code_rd ##0 (mpu_code_i == MPU_RW && !background_flash_operation_o)
      |=> bus_ack_o && bus_rdata_o == $past(code_rdata_i);
   endproperty
   a_code_ok: assert property (p_code_ok) else $error("code read");
   property p_mpu_na;
      s_code_rd ##0 (mpu_code_i == MPU_NO_ACCESS) |=> bus_err_o;
   endproperty
   a_mpu_na: assert property (p_mpu_na) else $error("no access");
   property p_cmd_rd;
      s_rd ##0 ((bus_addr_i & CMD_AREA_MASK) == CMD_AREA_BASE) |=> bus_err_o;
   endproperty
   a_cmd_rd: assert property (p_cmd_rd) else $error("cmd read");
   property p_uid;
      s_rd ##0 ((bus_addr_i & UID_MASK) == UID_BASE) |=> bus_ack_o &&
         bus_rdata_o == UNIQUE_ID[32*$past(bus_addr_i[3:2]) +: 32];
   endproperty
   a_uid: assert property (p_uid) else $error("uid word");
   property p_excl;
      !(bus_ack_o && bus_err_o);
   endproperty
   a_excl: assert property (p_excl) else $error("ack and err");
   property p_idle;
      !bus_req_i |=> !bus_ack_o && !bus_err_o;
   endproperty
   a_idle: assert property (p_idle) else $error("stray answer");
   property p_irq;
      irq_allowed_o;
   endproperty
   a_irq: assert property (p_irq) else $error("irq blocked");
   property p_blank;
      $rose(conn_req_i) && id_code_i == ID_BLANK |-> ##[1:4] conn_grant_o;
   endproperty
   a_blank: assert property (p_blank) else $error("blank id");
   property p_refuse;
      $rose(conn_req_i) && id_code_i != ID_BLANK &&
      debug_serial_id_setting_i == ID_MODE_REFUSE |-> ##[1:4] conn_deny_o;
   endproperty
   a_refuse: assert property (p_refuse) else $error("refuse id");
endmodule
bind flash_access_ctrl flash_access_props #(.UNIQUE_ID(UNIQUE_ID)) u_props (
   .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .bus_req_i(bus_req_i),
   .bus_we_i(bus_we_i), .bus_addr_i(bus_addr_i), .bus_ack_o(bus_ack_o),
   .bus_err_o(bus_err_o), .bus_rdata_o(bus_rdata_o),
   .code_rdata_i(code_rdata_i), .mpu_code_i(mpu_code_i),
   .background_flash_operation_o(background_flash_operation_o),
   .irq_allowed_o(irq_allowed_o), .id_code_i(id_code_i),
   .debug_serial_id_setting_i(debug_serial_id_setting_i),
   .conn_req_i(conn_req_i), .conn_grant_o(conn_grant_o),
   .conn_deny_o(conn_deny_o));

// >>> testbench/flash_array_model.sv
`timescale 1ns/1ps
module flash_array_model
   import flash_access_pkg::*;
#(
   parameter logic [31:0] DATA_INIT = 32'hA5A5_A5A5
)
(
   input wire logic sys_clk_i,
   input wire logic [31:0] bus_addr_i,
   input wire logic we_i,
   input wire logic erase_i,
   input wire logic [1:0] tgt_i,
   input wire logic [31:0] addr_i,
   input wire logic [31:0] wdata_i,
   output logic [31:0] code_rdata_o,
   output logic [31:0] data_rdata_o
);
   logic [31:0] code_q [128];
   logic [31:0] data_q [128];
   initial begin
      foreach (code_q[i]) code_q[i] = ERASED_WORD;
      foreach (data_q[i]) data_q[i] = DATA_INIT;
   end
   // Erasing data flash inverts every word instead of writing FF
   always @(posedge sys_clk_i) begin
      if (we_i && tgt_i == TGT_CODE) code_q[addr_i[8:2]] <= wdata_i;
      if (we_i && tgt_i == TGT_DATA) data_q[addr_i[8:2]] <= wdata_i;
      if (erase_i && tgt_i == TGT_CODE) begin
         foreach (code_q[i]) code_q[i] <= ERASED_WORD;
      end
      if (erase_i && tgt_i == TGT_DATA) begin
         foreach (data_q[i]) data_q[i] <= ~data_q[i];
      end
   end
   assign code_rdata_o = code_q[bus_addr_i[8:2]];
   assign data_rdata_o = data_q[bus_addr_i[8:2]];
endmodule

// >>> testbench/flash_access_and_id_protection_tb.sv
`timescale 1ns/1ps
module flash_access_and_id_protection_tb;
   import flash_access_pkg::*;
   localparam logic [127:0] UID = 128'h5A5A_1234_0F0F_9876_C3C3_2468_ABCD_1357;
   localparam logic [31:0] DINIT = 32'hA5A5_A5A5;
   localparam logic [127:0] IDX = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
   logic sys_clk_i = 1'h0, nrst_i = 1'h0, req = 1'h0, we = 1'h0, creq = 1'h0;
   logic rxd = 1'h1, sw = 1'h0, sec = 1'h0, s_ack, s_err;
   logic [31:0] addr = 32'h0, wd = 32'h0, prot = 32'h0, s_rd;
   logic [127:0] idc = ID_BLANK, cid = 128'h0;
   logic [1:0] ids = ID_MODE_REFUSE, mc = MPU_RW, md = MPU_RW;
   logic ack, err, flwe, fler, grant, deny, lock, busy, irq;
   logic [31:0] rd, fla, flw, crd, drd, er_a;
   logic [1:0] tgt;
   logic [15:0] bits;
   int error_cnt = 0, num_checks = 0, we_cnt = 0, er_cnt = 0;
   always #2.5 sys_clk_i = ~sys_clk_i;
   always @(negedge sys_clk_i) begin
      if (flwe === 1'h1) we_cnt++;
      if (fler === 1'h1) er_cnt++;
      if (fler === 1'h1) er_a = fla;
   end
   flash_access_ctrl #(.UNIQUE_ID(UID), .ERASE_CYCLES_P(20)) u_dut (
      .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .bus_req_i(req),
      .bus_we_i(we), .bus_addr_i(addr), .bus_wdata_i(wd),
      .bus_secure_i(sec), .bus_ack_o(ack), .bus_err_o(err),
      .bus_rdata_o(rd), .fl_we_o(flwe), .fl_erase_o(fler), .fl_tgt_o(tgt),
      .fl_addr_o(fla), .fl_wdata_o(flw), .code_rdata_i(crd),
      .data_rdata_i(drd), .id_code_i(idc), .debug_serial_id_setting_i(ids),
      .block_prot_i(prot), .mpu_code_i(mc), .mpu_data_i(md),
      .swap_sel_i(sw), .conn_req_i(creq), .conn_id_i(cid),
      .boot_rxd_i(rxd), .conn_grant_o(grant), .conn_deny_o(deny),
      .boot_bit_cycles_o(bits), .boot_locked_o(lock),
      .background_flash_operation_o(busy), .irq_allowed_o(irq));
   flash_array_model #(.DATA_INIT(DINIT)) u_mem (.sys_clk_i(sys_clk_i),
      .bus_addr_i(addr), .we_i(flwe), .erase_i(fler), .tgt_i(tgt),
      .addr_i(fla), .wdata_i(flw), .code_rdata_o(crd), .data_rdata_o(drd));
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] s, e);
      num_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // ----
   // Bus cycles
   // ----
   task automatic bus(input logic w, input logic [31:0] a, d);
      @(posedge sys_clk_i);
      req <= 1'h1;
      we <= w;
      addr <= a;
      wd <= d;
      @(posedge sys_clk_i);
      req <= 1'h0;
      #1;
      {s_ack, s_err, s_rd} = {ack, err, rd};
   endtask
   task automatic rdc(input string n, input logic [31:0] a, input logic k,
                      input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      check(n, {s_ack, s_err}, {k, ~k});
      if (k) check(n, s_rd, e);
   endtask
   task automatic cmd(input logic [31:0] d);
      bus(1'h1, CMD_AREA_BASE, d);
   endtask
   task automatic erase(input logic [1:0] t, input logic [31:0] a);
      cmd({16'h0, 6'h0, t, CMD_ERASE});
      cmd(a);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
      if (busy !== 1'h0) begin
         check("busy timeout", 32'h1, 32'h0);
         report_and_stop();
      end
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_map();
      logic [1:0] m;
      check("irq", {31'h0, irq}, 32'h1);
      rdc("erased", 32'h40, 1'h1, ERASED_WORD);
      for (int i = 0; i < 4; i++) begin
         rdc("uid", UID_BASE + 4 * i, 1'h1, UID[32*i +: 32]);
      end
      rdc("cmd read", CMD_AREA_BASE, 1'h0, 32'h0);
      rdc("unmapped", 32'h3000_0000, 1'h0, 32'h0);
      bus(1'h1, 32'h40, 32'h0);
      check("code write", {31'h0, s_err}, 32'h1);
      for (int i = 0; i < 3; i++) begin
         m = (i == 2) ? MPU_NO_ACCESS : 2'(i);
         @(posedge sys_clk_i);
         mc <= m;
         md <= m;
         rdc("mpu code", 32'h40, m != MPU_NO_ACCESS, ERASED_WORD);
         rdc("mpu data", DATA_BASE, m != MPU_NO_ACCESS, DINIT);
      end
      @(posedge sys_clk_i);
      {mc, md} <= {MPU_RW, MPU_RW};
      $display("map test done");
   endtask
   task automatic t_prog();
      cmd({16'h0, 6'h0, TGT_CODE, CMD_PROGRAM});
      cmd(32'h100);
      we_cnt = 0;
      for (int i = 0; i < CODE_PROG_WORDS; i++) cmd(32'hC0DE_0000 + i);
      cmd({24'h0, CMD_CONFIRM});
      rdc("busy code", 32'h100, 1'h0, 32'h0);
      check("bgo flag", {31'h0, busy}, 32'h1);
      check("irq busy", {31'h0, irq}, 32'h1);
      settle(10);
      check("words", 32'(we_cnt), 32'(CODE_PROG_WORDS));
      rdc("word0", 32'h100, 1'h1, 32'hC0DE_0000);
      rdc("word31", 32'h17C, 1'h1, 32'hC0DE_001F);
      $display("program test done");
   endtask
   task automatic t_erase();
      er_cnt = 0;
      erase(TGT_DATA, DATA_BASE);
      rdc("bgo code", 32'h100, 1'h1, 32'hC0DE_0000);
      rdc("busy data", DATA_BASE, 1'h0, 32'h0);
      settle(30);
      check("data erase", 32'(er_cnt), 32'h1);
      @(posedge sys_clk_i);
      {prot, sec} <= {32'h1, 1'h1};
      erase(TGT_CODE, CODE_BASE);
      settle(30);
      check("prot erase", 32'(er_cnt), 32'h1);
      rdc("prot kept", 32'h100, 1'h1, 32'hC0DE_0000);
      @(posedge sys_clk_i);
      {prot, sec} <= {32'h0, 1'h0};
      erase(TGT_CODE, CODE_BASE);
      rdc("bgo data", DATA_BASE, 1'h1, ~DINIT);
      settle(30);
      check("erase addr", er_a, CODE_BASE);
      rdc("erased blk", 32'h100, 1'h1, ERASED_WORD);
      @(posedge sys_clk_i);
      sw <= 1'h1;
      erase(TGT_CODE, CODE_BASE);
      settle(30);
      check("swap blk", er_a, 32'(CODE_BLOCK_BYTES));
      @(posedge sys_clk_i);
      sw <= 1'h0;
      $display("erase test done");
   endtask
   task automatic conn(input logic [127:0] i, c, input logic [1:0] s,
                       input logic g);
      int n;
      @(posedge sys_clk_i);
      {idc, cid, ids, creq} <= {i, c, s, 1'h1};
      for (n = 0; n < 10 && (grant | deny) !== 1'h1; n++) @(posedge sys_clk_i);
      #1;
      check("conn", {grant, deny}, {g, ~g});
      @(posedge sys_clk_i);
      creq <= 1'h0;
      repeat (5) @(posedge sys_clk_i);
      #1;
      check("conn drop", {grant, deny}, 32'h0);
   endtask
   task automatic t_conn_baud();
      int n;
      conn(ID_BLANK, 128'h0, ID_MODE_REFUSE, 1'h1);
      conn(IDX, IDX, ID_MODE_REFUSE, 1'h0);
      conn(IDX, IDX, ID_MODE_MATCH, 1'h1);
      conn(IDX, ~IDX, ID_MODE_MATCH, 1'h0);
      @(posedge sys_clk_i);
      rxd <= 1'h0;
      repeat (10) @(posedge sys_clk_i);
      rxd <= 1'h1;
      for (n = 0; n < 20 && lock !== 1'h1; n++) @(posedge sys_clk_i);
      check("baud lock", {31'h0, lock}, 32'h1);
      check("baud rate", {16'h0, bits}, 32'h0000_000A);
      $display("connection test done");
   endtask
   initial begin
      repeat (10) @(posedge sys_clk_i);
      nrst_i <= 1'h1;
      t_map();
      t_prog();
      t_erase();
      t_conn_baud();
      report_and_stop();
   end
endmodule
